/* File: src/spi_port.sv */
`default_nettype none
module spi_port (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// Register bus
	input  wire spi_port_pkg::apb_req_t apb_req,
	output var  spi_port_pkg::apb_rsp_t apb_rsp,
	// Serial pins
	input  wire spi_port_pkg::pin_in_t  pins_in,
	output var  spi_port_pkg::pin_out_t pins_out,
	// Neighbouring interrupt logic
	input  wire logic                  timer1_irq_event,
	output logic [spi_port_pkg::IE_W-1:0] irq_enable_mask,
	output logic                       serial_irq
);
	import spi_port_pkg::*;

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [BYTE_W-1:0] read_buffer_q, write_buffer_q, shift_register_q;
	logic              clock_edge_select_q, port_enable_q;
	logic              read_overflow_q, shift_go_q;
	logic [RATE_W-1:0] rate_select_field_q;
	logic              rx_full_q, rx_full_irq_flag_q, timer1_irq_flag_q;
	logic              sdo_open_drain_q, sck_open_drain_q;
	logic [IE_W-1:0]   ie_q;
	logic [CNT_W-1:0]  bit_cnt_q;
	logic              started_q, sck_q, sck_prev_q, t1_prev_q, sdo_q;
	logic [DIV_W-1:0]  div_q;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	logic access, setup, wr_en, rd_en;
	logic hit_rb, hit_wb, hit_sts, hit_ctl, hit_ie, hit_any;
	logic [BYTE_W-1:0] wbyte, rd_byte;

	assign access  = apb_req.psel & apb_req.penable & apb_rsp.pready;
	assign setup   = apb_req.psel & ~apb_req.penable;
	assign wr_en   = access & apb_req.pwrite;
	assign rd_en   = access & ~apb_req.pwrite;
	assign hit_rb  = apb_req.paddr == ADDR_READ_BUF;
	assign hit_wb  = apb_req.paddr == ADDR_WRITE_BUF;
	assign hit_sts = apb_req.paddr == ADDR_STATUS;
	assign hit_ctl = apb_req.paddr == ADDR_CONTROL;
	assign hit_ie  = apb_req.paddr == ADDR_IRQ_EN;
	assign hit_any = hit_rb | hit_wb | hit_sts | hit_ctl | hit_ie;
	assign wbyte   = apb_req.pwdata[BYTE_W-1:0];

	always_comb begin
		rd_byte = RST_BYTE;
		if (hit_rb) begin
			rd_byte = read_buffer_q;
		end
		if (hit_wb) begin
			rd_byte = write_buffer_q;
		end
		if (hit_sts) begin
			// Status layout, upper bits zero
			rd_byte[STS_T1F]     = timer1_irq_flag_q;
			rd_byte[STS_SDO_OD]  = sdo_open_drain_q;
			rd_byte[STS_SCK_OD]  = sck_open_drain_q;
			rd_byte[STS_RXF_IRQ] = rx_full_irq_flag_q;
			rd_byte[STS_RXF]     = rx_full_q;
		end
		if (hit_ctl) begin
			rd_byte[CTL_CES] = clock_edge_select_q;
			rd_byte[CTL_EN]  = port_enable_q;
			rd_byte[CTL_OVF] = read_overflow_q;
			rd_byte[CTL_GO]  = shift_go_q;
			rd_byte[RATE_W-1:0] = rate_select_field_q;
		end
		if (hit_ie) begin
			rd_byte[IE_W-1:0] = ie_q;
		end
	end

	// ****************************************************************
	// Mode and edge events
	// ****************************************************************
	logic is_master, ss_mode, selected, active, tick, s_rise, s_fall;
	logic drive_ev, samp_ev, done, overflow_ev, copy_ev;
	logic wb_write, rb_read, abort, sdo_d, sck_d;
	logic [DIV_W-1:0] half;
	logic [BYTE_W-1:0] rx_shift;

	// Mode from rate code
	assign is_master = (rate_select_field_q != RATE_SLAVE_SS)
		& (rate_select_field_q != RATE_SLAVE_FREE);
	assign ss_mode = rate_select_field_q == RATE_SLAVE_SS;
	assign selected = is_master | ~ss_mode | ~pins_in.ss_n;
	assign active = port_enable_q & shift_go_q;
	assign half = (DIV_ONE << rate_select_field_q) - DIV_ONE;
	assign tick = (rate_select_field_q == RATE_TIMER1)
		? (pins_in.timer1_output & ~t1_prev_q) : (div_q == half);
	assign s_rise = pins_in.sck & ~sck_prev_q;
	assign s_fall = ~pins_in.sck & sck_prev_q;

	always_comb begin
		drive_ev = 1'b0;
		samp_ev  = 1'b0;
		if (active & selected) begin
			if (is_master) begin
				drive_ev = tick & (sck_q == clock_edge_select_q);
				samp_ev  = tick & (sck_q != clock_edge_select_q);
			end else if (clock_edge_select_q) begin
				drive_ev = s_fall;
				samp_ev  = s_rise;
			end else begin
				drive_ev = s_rise;
				samp_ev  = s_fall;
			end
		end
	end

	assign rx_shift = {shift_register_q[BYTE_W-2:0], pins_in.sdi};
	assign done = samp_ev & (bit_cnt_q == LAST_BIT);
	assign overflow_ev = done & ~is_master & rx_full_q;
	assign copy_ev = done & ~overflow_ev;
	assign wb_write = wr_en & hit_wb & ~started_q;
	assign rb_read = rd_en & hit_rb;
	assign abort = ~port_enable_q | (ss_mode & pins_in.ss_n);
	assign sdo_d = drive_ev ? shift_register_q[BYTE_W-1] : sdo_q;
	assign sck_d = (~is_master | ~active) ? clock_edge_select_q
		: (tick ? ~sck_q : sck_q);

	// ****************************************************************
	// APB response
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready <= setup & ~apb_rsp.pready;
			if (setup) begin
				apb_rsp.pslverr <= ~hit_any;
				apb_rsp.prdata  <= DATA_W'(rd_byte);
			end
		end
	end

	// ****************************************************************
	// Control register
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_edge_select_q <= 1'b0;
			port_enable_q       <= 1'b0;
			rate_select_field_q <= RST_RATE;
		end else if (wr_en & hit_ctl) begin
			clock_edge_select_q <= wbyte[CTL_CES];
			port_enable_q       <= wbyte[CTL_EN];
			rate_select_field_q <= wbyte[RATE_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_go_q <= 1'b0;
		end else if (wr_en & hit_ctl & wbyte[CTL_GO]) begin
			shift_go_q <= 1'b1;
		end else if (done) begin
			shift_go_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			read_overflow_q <= 1'b0;
		end else if (overflow_ev) begin
			read_overflow_q <= 1'b1;
		end else if (wr_en & hit_ctl & ~wbyte[CTL_OVF]) begin
			read_overflow_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Status and enable registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_full_q <= 1'b0;
		end else if (copy_ev) begin
			rx_full_q <= 1'b1;
		end else if (rb_read | (wr_en & hit_sts & ~wbyte[STS_RXF])) begin
			rx_full_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_full_irq_flag_q <= 1'b0;
		end else if (copy_ev) begin
			rx_full_irq_flag_q <= 1'b1;
		end else if (wr_en & hit_sts & ~wbyte[STS_RXF_IRQ]) begin
			rx_full_irq_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer1_irq_flag_q <= 1'b0;
		end else if (timer1_irq_event) begin
			timer1_irq_flag_q <= 1'b1;
		end else if (wr_en & hit_sts & ~wbyte[STS_T1F]) begin
			timer1_irq_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdo_open_drain_q <= 1'b0;
			sck_open_drain_q <= 1'b0;
		end else if (wr_en & hit_sts) begin
			sdo_open_drain_q <= wbyte[STS_SDO_OD];
			sck_open_drain_q <= wbyte[STS_SCK_OD];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ie_q <= RST_IE;
		end else if (wr_en & hit_ie) begin
			ie_q <= wbyte[IE_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_irq      <= 1'b0;
			irq_enable_mask <= RST_IE;
		end else begin
			serial_irq      <= rx_full_irq_flag_q & ie_q[IE_SERIAL];
			irq_enable_mask <= ie_q;
		end
	end

	// ****************************************************************
	// Buffers and shifter
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			read_buffer_q <= RST_BYTE;
		end else if (copy_ev) begin
			read_buffer_q <= rx_shift;
		end else if (wr_en & hit_rb) begin
			read_buffer_q <= wbyte;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_buffer_q <= RST_BYTE;
		end else if (wb_write) begin
			write_buffer_q <= wbyte;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_register_q <= RST_BYTE;
		end else if (wb_write) begin
			shift_register_q <= wbyte;
		end else if (samp_ev) begin
			shift_register_q <= rx_shift;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_q <= '0;
			started_q <= 1'b0;
		end else if (abort | done) begin
			bit_cnt_q <= '0;
			started_q <= 1'b0;
		end else begin
			if (drive_ev | samp_ev) begin
				started_q <= 1'b1;
			end
			if (samp_ev) begin
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
		end
	end

	// ****************************************************************
	// Master clock generation and edge history
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= '0;
			sck_q <= 1'b0;
		end else if (~is_master | ~active) begin
			div_q <= '0;
			sck_q <= clock_edge_select_q;
		end else if (tick) begin
			div_q <= '0;
			sck_q <= ~sck_q;
		end else begin
			div_q <= div_q + DIV_ONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_prev_q <= 1'b0;
			t1_prev_q  <= 1'b0;
			sdo_q      <= 1'b0;
		end else begin
			sck_prev_q <= pins_in.sck;
			t1_prev_q  <= pins_in.timer1_output;
			sdo_q      <= sdo_d;
		end
	end

	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_out.sck      <= 1'b0;
			pins_out.sck_oe_n <= 1'b1;
			pins_out.sdo      <= 1'b0;
			pins_out.sdo_oe_n <= 1'b1;
		end else begin
			pins_out.sck <= sck_d;
			pins_out.sck_oe_n <= ~(port_enable_q & is_master
				& (~sck_open_drain_q | ~sck_d));
			pins_out.sdo <= sdo_d;
			pins_out.sdo_oe_n <= ~(port_enable_q & selected
				& (~sdo_open_drain_q | ~sdo_d));
		end
	end
endmodule // spi_port
`default_nettype wire

/* File: src/spi_port_pkg.sv */
// Function
// - Edge select clear: drive on SCK rise, sample on fall, hold while low.
// - Edge select set: drive on SCK fall, sample on rise, hold while high.
// - Port enable bit switches the serial port on and off.
// - Slave byte completing over an unread buffer sets overflow; byte is lost.
// - Software sets shift go; it stays set and only hardware clears it.
// - Rate codes 0-4 divide pclk by 2 to 32; code 7 halves timer1.
// - Code 5 is slave honouring select, code 6 slave ignoring it.
// - Master mode ignores the slave select input.
// - Serial irq enable gates the read-buffer-full interrupt.
// - Enable register holds timer1, external and tick enables too.
// - Completed byte goes to read buffer, setting full and irq flags.
// - Loaded byte waits, shifting from first SCK edge while shift go.
// - Full irq flag reads 1 after a completed byte.
// - Full flag reads 1 while the read buffer holds a byte.
// - Status bits 3 and 2 make SDO and SCK open-drain.
// - Status bit 4 is the timer1 flag; bits 7 to 5 read 0.
// - Bytes shift most significant bit first both ways.
// - Reading the read buffer clears the full flag.
// - Write buffer rejects writes until the current shift completes.
// - With select honoured, select high idles the slave and frees SDO.
`default_nettype none
package spi_port_pkg;
	// ****************************************************************
	// Bus widths and register map
	// ****************************************************************
	localparam int APB_AW = 8;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam logic [APB_AW-1:0] IDX_READ_BUF  = 8'h0A;
	localparam logic [APB_AW-1:0] IDX_WRITE_BUF = 8'h0B;
	localparam logic [APB_AW-1:0] IDX_STATUS    = 8'h0C;
	localparam logic [APB_AW-1:0] IDX_CONTROL   = 8'h0D;
	localparam logic [APB_AW-1:0] IDX_IRQ_EN    = 8'h0F;
	localparam logic [APB_AW-1:0] ADDR_READ_BUF  = IDX_READ_BUF << 2;
	localparam logic [APB_AW-1:0] ADDR_WRITE_BUF = IDX_WRITE_BUF << 2;
	localparam logic [APB_AW-1:0] ADDR_STATUS    = IDX_STATUS << 2;
	localparam logic [APB_AW-1:0] ADDR_CONTROL   = IDX_CONTROL << 2;
	localparam logic [APB_AW-1:0] ADDR_IRQ_EN    = IDX_IRQ_EN << 2;
	// ****************************************************************
	// Field positions and codes
	// ****************************************************************
	localparam int CTL_CES = 7;
	localparam int CTL_EN = 6;
	localparam int CTL_OVF = 5;
	localparam int CTL_GO = 4;
	localparam int RATE_W = 3;
	localparam int STS_T1F = 4;
	localparam int STS_SDO_OD = 3;
	localparam int STS_SCK_OD = 2;
	localparam int STS_RXF_IRQ = 1;
	localparam int STS_RXF = 0;
	localparam int IE_W = 4;
	localparam int IE_SERIAL = 2;
	localparam logic [RATE_W-1:0] RATE_SLAVE_SS   = 3'h5;
	localparam logic [RATE_W-1:0] RATE_SLAVE_FREE = 3'h6;
	localparam logic [RATE_W-1:0] RATE_TIMER1     = 3'h7;
	localparam int DIV_W = 5;
	localparam logic [DIV_W-1:0] DIV_ONE = 5'h01;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] LAST_BIT = 4'h7;
	localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
	localparam logic [RATE_W-1:0] RST_RATE = 3'h0;
	localparam logic [IE_W-1:0] RST_IE = 4'h0;
	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [APB_AW-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;
	typedef struct packed {
		logic              pready;
		logic              pslverr;
		logic [DATA_W-1:0] prdata;
	} apb_rsp_t;
	typedef struct packed {
		logic sck;
		logic sdi;
		logic ss_n;
		logic timer1_output;
	} pin_in_t;
	typedef struct packed {
		logic sck;
		logic sck_oe_n;
		logic sdo;
		logic sdo_oe_n;
	} pin_out_t;
endpackage
`default_nettype wire

/* File: testbench/spi_port_props.sv */
`default_nettype none
module spi_port_props (
	// Clock and reset
	input wire logic                            pclk,
	input wire logic                            presetn,
	// Register bus
	input wire spi_port_pkg::apb_req_t          apb_req,
	input wire spi_port_pkg::apb_rsp_t          apb_rsp,
	// Serial pins
	input wire spi_port_pkg::pin_in_t           pins_in,
	input wire spi_port_pkg::pin_out_t          pins_out,
	// Interrupt side
	input wire logic                            timer1_irq_event,
	input wire logic [spi_port_pkg::IE_W-1:0]   irq_enable_mask,
	input wire logic                            serial_irq
);
	timeunit 1ns;
	timeprecision 100ps;
	import spi_port_pkg::*;
	// ************
	// Shadow of written fields
	// ************
	logic [7:0] ctl_q;
	logic [1:0] od_q;
	logic [3:0] ie_q;
	logic       wr;
	logic       slv;
	assign wr = apb_req.psel & apb_req.penable & apb_rsp.pready
		& apb_req.pwrite;
	assign slv = ctl_q[CTL_EN] & (ctl_q[2:0] == RATE_SLAVE_SS
		| ctl_q[2:0] == RATE_SLAVE_FREE);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= 8'h00;
			od_q <= 2'h0;
			ie_q <= 4'h0;
		end else if (wr) begin
			if (apb_req.paddr == ADDR_CONTROL) ctl_q <= apb_req.pwdata[7:0];
			if (apb_req.paddr == ADDR_STATUS) od_q <= apb_req.pwdata[3:2];
			if (apb_req.paddr == ADDR_IRQ_EN) ie_q <= apb_req.pwdata[3:0];
		end
	end
	// ************
	// Properties
	// ************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_sts_top;
		apb_req.psel && !apb_req.penable && !apb_req.pwrite
			&& apb_req.paddr == ADDR_STATUS |=> apb_rsp.prdata[7:5] == 3'h0;
	endproperty
	a_sts_top: assert property (p_sts_top) else $error("status top set");
	property p_irq_gate;
		!irq_enable_mask[IE_SERIAL] [*2] |-> !serial_irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq unmasked");
	property p_off;
		!ctl_q[CTL_EN] [*3] |-> pins_out.sdo_oe_n && pins_out.sck_oe_n;
	endproperty
	a_off: assert property (p_off) else $error("pins driven when off");
	property p_ss_idle;
		(ctl_q[CTL_EN] && ctl_q[2:0] == RATE_SLAVE_SS && pins_in.ss_n) [*4]
			|-> pins_out.sdo_oe_n;
	endproperty
	a_ss_idle: assert property (p_ss_idle) else $error("sdo driven");
	property p_od_sck;
		od_q[0] [*3] ##0 !pins_out.sck_oe_n |-> !pins_out.sck;
	endproperty
	a_od_sck: assert property (p_od_sck) else $error("sck drives high");
	property p_od_sdo;
		od_q[1] [*3] ##0 !pins_out.sdo_oe_n |-> !pins_out.sdo;
	endproperty
	a_od_sdo: assert property (p_od_sdo) else $error("sdo drives high");
	property p_slv_sck;
		slv [*3] |-> pins_out.sck_oe_n;
	endproperty
	a_slv_sck: assert property (p_slv_sck) else $error("slave drives sck");
	property p_mask;
		$changed(ie_q) |-> ##[0:1] irq_enable_mask == ie_q;
	endproperty
	a_mask: assert property (p_mask) else $error("mask not copied");
	c_irq: cover property ($rose(serial_irq));
	c_slv: cover property (slv && !pins_out.sdo_oe_n);
	c_err: cover property (apb_rsp.pslverr);
endmodule // spi_port_props
`default_nettype wire

/* File: testbench/spi_peer.sv */
`default_nettype none
module spi_peer (
	// Bench control
	input  wire logic                   pclk,
	input  wire logic                   arm,
	input  wire logic                   own,
	input  wire logic                   clock_edge_select,
	input  wire logic                   sel,
	input  wire logic [7:0]             tx,
	// Line side
	input  wire spi_port_pkg::pin_out_t po,
	output var  logic                   sck,
	output wire logic                   sdi,
	output wire logic                   ss_n,
	output var  logic [7:0]             rx
);
	timeunit 1ns;
	timeprecision 100ps;
	import spi_port_pkg::*;
	logic       k;
	logic       fr = 1'b0;
	logic       bit_q = 1'b0;
	logic       pat = 1'b0;
	logic [7:0] sh = 8'h00;
	logic [4:0] n = 5'h00;
	logic [7:0] b;
	initial sck = 1'b0;
	initial rx = 8'h00;
	assign k = own ? sck : (po.sck_oe_n | po.sck);
	assign sdi = (own & ~fr) ? pat : bit_q;
	assign ss_n = ~(sel & fr);
	always @(posedge pclk) pat <= ~pat;
	// Own clock idles at the edge select level
	always @(posedge pclk) if (!own) sck <= clock_edge_select;
	always @(k) begin
		if (!arm) begin
			n <= 5'h00;
		end else if (k ^ clock_edge_select) begin
			b = (n == 5'h00) ? tx : sh;
			bit_q <= b[7];
			sh <= {b[6:0], 1'b0};
			n <= n + 5'h01;
		end else if (n != 5'h00) begin
			rx <= {rx[6:0], po.sdo_oe_n | po.sdo};
			n <= (n == 5'h0F) ? 5'h00 : n + 5'h01;
		end
	end
	task automatic frame();
		fr <= 1'b1;
		repeat (16) begin
			repeat (8) @(posedge pclk);
			sck <= ~sck;
		end
		repeat (8) @(posedge pclk);
		fr <= 1'b0;
		@(posedge pclk);
	endtask
endmodule // spi_peer
`default_nettype wire

/* File: testbench/spi_port_tb.sv */
`default_nettype none
module spi_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import spi_port_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic t1 = 1'b0;
	logic t1ev = 1'b0;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	pin_in_t pin;
	pin_out_t po;
	logic [3:0] iem;
	logic sirq, psck, psdi, pss;
	logic arm = 1'b0, own = 1'b0, clock_edge_select = 1'b0, sel = 1'b0;
	logic [7:0] ptx = 8'h00, prx, rdv, tx, rb;
	logic [2:0] rates [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
	logic [8:0] q_e [$];
	logic [8:0] q_m [$];
	int errors = 0, cmp_count = 0, seed = 22, cyc = 0;
	assign pin = {psck, psdi, pss, t1};
	always #2 pclk = ~pclk;
	spi_port dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req),
		.apb_rsp(rsp), .pins_in(pin), .pins_out(po), .timer1_irq_event(t1ev),
		.irq_enable_mask(iem), .serial_irq(sirq));
	spi_peer peer_u (.pclk(pclk), .arm(arm), .own(own), .clock_edge_select(clock_edge_select),
		.sel(sel), .tx(ptx), .po(po), .sck(psck), .sdi(psdi), .ss_n(pss),
		.rx(prx));
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(logic [8:0] s, logic [8:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [7:0] d);
		req <= '{1'b1, 1'b0, w, a, {24'h000000, d}};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		rdv = rsp.prdata[7:0];
		req <= '0;
		@(posedge pclk);
	endtask
	task automatic rd(logic [7:0] a, logic [8:0] e, logic [8:0] m = 9'h1FF);
		q_e.push_back(e & m);
		q_m.push_back(m);
		apb(1'b0, a, 8'h00);
	endtask
	task automatic wait_rx();
		int i;
		i = 0;
		do begin
			rd(ADDR_STATUS, 9'h000, 9'h000);
			i++;
		end while (rdv[STS_RXF] !== 1'b1 && i < 400);
		check({8'h00, i < 400}, 9'h001);
	endtask
	always @(posedge pclk)
		if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite)
			check({rsp.pslverr, rsp.prdata[7:0]} & q_m.pop_front(),
				q_e.pop_front());
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		t1 <= t1 ^ (cyc % 3 == 0);
		if (cyc == 20000) begin
			errors++;
			stop_test();
		end
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ADDR_STATUS, 9'h000);
		rd(ADDR_CONTROL, 9'h000);
		rd(ADDR_IRQ_EN, 9'h000);
		rd(8'h38, 9'h100);
		apb(1'b1, ADDR_IRQ_EN, 8'hFF);
		rd(ADDR_IRQ_EN, 9'h00F);
		apb(1'b1, ADDR_STATUS, 8'hFF);
		rd(ADDR_STATUS, 9'h00C);
		t1ev <= 1'b1;
		@(posedge pclk);
		t1ev <= 1'b0;
		rd(ADDR_STATUS, 9'h01C);
		apb(1'b1, ADDR_STATUS, 8'h0C);
		$display("register test done");
		foreach (rates[i]) begin
			clock_edge_select = $random(seed);
			tx = $random(seed);
			ptx = $random(seed);
			apb(1'b1, ADDR_CONTROL, {clock_edge_select, 1'b1, 3'b000, rates[i]});
			repeat (4) @(posedge pclk);
			arm <= 1'b1;
			apb(1'b1, ADDR_WRITE_BUF, tx);
			apb(1'b1, ADDR_CONTROL, {clock_edge_select, 1'b1, 2'b01, 1'b0, rates[i]});
			repeat (40) @(posedge pclk);
			apb(1'b1, ADDR_WRITE_BUF, ~tx);
			wait_rx();
			check({1'b0, prx}, {1'b0, tx});
			rd(ADDR_READ_BUF, ptx);
			rd(ADDR_STATUS, 9'h002, 9'h1F3);
			rd(ADDR_CONTROL, {clock_edge_select, 1'b1, 3'b000, rates[i]});
			check({8'h00, sirq}, 9'h001);
			apb(1'b1, ADDR_STATUS, 8'h00);
			arm <= 1'b0;
		end
		$display("master test done");
		own = 1'b1;
		apb(1'b1, ADDR_CONTROL, {clock_edge_select, 1'b1, 3'b000, RATE_SLAVE_FREE});
		arm <= 1'b1;
		for (int j = 0; j < 2; j++) begin
			tx = $random(seed);
			ptx = $random(seed);
			if (j == 0) rb = ptx;
			apb(1'b1, ADDR_WRITE_BUF, tx);
			apb(1'b1, ADDR_CONTROL, {clock_edge_select, 1'b1, 2'b01, 1'b0, RATE_SLAVE_FREE});
			peer_u.frame();
			check({1'b0, prx}, {1'b0, tx});
		end
		rd(ADDR_CONTROL, {clock_edge_select, 1'b1, 3'b100, RATE_SLAVE_FREE});
		rd(ADDR_READ_BUF, rb);
		apb(1'b1, ADDR_WRITE_BUF, tx);
		apb(1'b1, ADDR_CONTROL, {clock_edge_select, 1'b1, 2'b01, 1'b0, RATE_SLAVE_SS});
		peer_u.frame();
		rd(ADDR_STATUS, 9'h002);
		sel <= 1'b1;
		peer_u.frame();
		check({1'b0, prx}, {1'b0, tx});
		rd(ADDR_READ_BUF, ptx);
		$display("slave test done");
		apb(1'b1, ADDR_IRQ_EN, 8'h00);
		repeat (2) @(posedge pclk);
		check({8'h00, sirq}, 9'h000);
		apb(1'b1, ADDR_IRQ_EN, 8'h04);
		repeat (2) @(posedge pclk);
		check({8'h00, sirq}, 9'h001);
		apb(1'b1, ADDR_CONTROL, 8'h00);
		repeat (4) @(posedge pclk);
		$display("interrupt test done");
		stop_test();
	end
endmodule // spi_port_tb
bind spi_port spi_port_props chk_u (.pclk(pclk), .presetn(presetn),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .pins_in(pins_in),
	.pins_out(pins_out), .timer1_irq_event(timer1_irq_event),
	.irq_enable_mask(irq_enable_mask), .serial_irq(serial_irq));
`default_nettype wire
